// ==== src/dscw_bank.sv ====
// dscw_bank.sv: drive status word, speed feedback and network command word
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "dscw_defines.svh"

module dscw_bank (
   // clock and reset
   input  wire  logic               core_clk,
   input  wire  logic               rst,
   // parameter access port
   input  wire  logic               paramRead,
   input  wire  logic               paramWrite,
   input  wire  logic [1:0]         paramIndex,
   input  wire  logic [15:0]        paramWrData,
   input  wire  dscw_pkg::dscw_src_t paramSource,
   output var   logic [15:0]        paramRdData_q,
   output var   logic               paramRdValid_q,
   output var   logic               paramWrRefused_q,
   // command source configuration
   input  wire  logic               fieldbusSelected,
   input  wire  logic               localRemoteFromBus,
   input  wire  logic               rampSetFromBus,
   // drive conditions
   input  wire  logic               quickStopActive,
   input  wire  logic               configMode,
   input  wire  logic               alarmPresent,
   input  wire  logic               motorRunning,
   input  wire  logic               driveReady,
   input  wire  logic               rotatingForward,
   input  wire  logic               panelRemote,
   input  wire  logic               panelRamp2,
   input  wire  logic               panelInch,
   input  wire  logic               underVoltage,
   input  wire  logic               controllerAuto,
   input  wire  logic               faultPresent,
   input  wire  logic signed [15:0] actualSpeed,
   input  wire  logic [15:0]        ratedMotorFrequency,
   input  wire  logic signed [15:0] speedReference,
   // commands toward the drive core
   output var   logic               runCmd_q,
   output var   logic               decelStop_q,
   output var   logic               enableCmd_q,
   output var   logic               inchCmd_q,
   output var   logic               remoteMode_q,
   output var   logic               ramp2Select_q,
   output var   logic               quickStopCmd_q,
   output var   logic               faultResetPulse_q,
   output var   logic signed [15:0] effectiveReference_q
);

   logic [15:0]        commandWord_q;
   logic [15:0]        statusWord;
   logic signed [15:0] speedWord_q;
   logic               fltRstPrev_q;
   logic               runPrev_q;
   logic               busRules;
   dscw_pkg::dscw_state_t accState_q;

   assign busRules = fieldbusSelected;

   // ------------------------------------------------------------
   // speed feedback scaling
   // ------------------------------------------------------------
   dscw_speed_scale uScale (
      .core_clk    (core_clk),
      .rst         (rst),
      .actualSpeed (actualSpeed),
      .ratedFreq   (ratedMotorFrequency),
      .speedWord_q (speedWord_q)
   );

   // ------------------------------------------------------------
   // status word assembly from live conditions and the registered command outputs
   // ------------------------------------------------------------
   always_comb begin
      statusWord = 16'h0000;
      statusWord[`DSCW_ST_QSTOP]   = quickStopActive;
      statusWord[`DSCW_ST_RAMP2]   = ramp2Select_q;
      statusWord[`DSCW_ST_CONFIG]  = configMode;
      statusWord[`DSCW_ST_ALARM]   = alarmPresent;
      statusWord[`DSCW_ST_RUNNING] = motorRunning;
      statusWord[`DSCW_ST_ENABLED] = enableCmd_q & driveReady & ~configMode;
      statusWord[`DSCW_ST_FORWARD] = rotatingForward;
      statusWord[`DSCW_ST_INCH]    = inchCmd_q;
      statusWord[`DSCW_ST_REMOTE]  = remoteMode_q;
      statusWord[`DSCW_ST_UNDERV]  = underVoltage;
      statusWord[`DSCW_ST_AUTO]    = controllerAuto;
      statusWord[`DSCW_ST_FAULT]   = faultPresent;
   end

   // ------------------------------------------------------------
   // access state
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         accState_q <= dscw_pkg::DSCW_IDLE;
      end else begin
         case (accState_q)
            dscw_pkg::DSCW_IDLE: begin
               if (paramRead || paramWrite) begin
                  accState_q <= dscw_pkg::DSCW_ACCESS;
               end
            end
            dscw_pkg::DSCW_ACCESS: begin
               if (!(paramRead || paramWrite)) begin
                  accState_q <= dscw_pkg::DSCW_IDLE;
               end
            end
            default: begin
               accState_q <= dscw_pkg::DSCW_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // read path, no side effect
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         paramRdData_q <= 16'h0000;
      end else begin
         if (paramRead) begin
            case (paramIndex)
               `DSCW_IDX_STATUS:  paramRdData_q <= statusWord;
               `DSCW_IDX_SPEED:   paramRdData_q <= speedWord_q;
               `DSCW_IDX_COMMAND: paramRdData_q <= commandWord_q;
               default:           paramRdData_q <= 16'h0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // read valid, one cycle per read cycle
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         paramRdValid_q <= 1'b0;
      end else begin
         paramRdValid_q <= paramRead;
      end
   end

   // ------------------------------------------------------------
   // command word write, fieldbus only
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         commandWord_q <= `DSCW_CMD_RESET;
      end else if (paramWrite && paramIndex == `DSCW_IDX_COMMAND &&
                   paramSource == dscw_pkg::DSCW_SRC_FIELDBUS) begin
         commandWord_q <= paramWrData & `DSCW_CW_USED_MASK;
      end
   end

   // ------------------------------------------------------------
   // write refusal, one cycle per refused write
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         paramWrRefused_q <= 1'b0;
      end else begin
         paramWrRefused_q <= paramWrite && (paramIndex != `DSCW_IDX_COMMAND ||
                                            paramSource != dscw_pkg::DSCW_SRC_FIELDBUS);
      end
   end

   // ------------------------------------------------------------
   // command decode, gated by command source
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         runCmd_q <= 1'b0;
      end else if (busRules) begin
         runCmd_q <= commandWord_q[`DSCW_CW_RUN];
      end else begin
         runCmd_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // general enable command
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enableCmd_q <= 1'b0;
      end else if (busRules) begin
         enableCmd_q <= commandWord_q[`DSCW_CW_ENABLE];
      end else begin
         enableCmd_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // jog command, panel value when bus not in control
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         inchCmd_q <= 1'b0;
      end else if (busRules) begin
         inchCmd_q <= commandWord_q[`DSCW_CW_INCH];
      end else begin
         inchCmd_q <= panelInch;
      end
   end

   // ------------------------------------------------------------
   // quick stop command
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         quickStopCmd_q <= 1'b0;
      end else if (busRules) begin
         quickStopCmd_q <= commandWord_q[`DSCW_CW_QSTOP];
      end else begin
         quickStopCmd_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // previous run command
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         runPrev_q <= 1'b0;
      end else begin
         runPrev_q <= runCmd_q;
      end
   end

   // ------------------------------------------------------------
   // deceleration stop on run falling, or while motor running with run off
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         decelStop_q <= 1'b0;
      end else begin
         if (runCmd_q) begin
            decelStop_q <= 1'b0;
         end else if (runPrev_q || motorRunning) begin
            decelStop_q <= 1'b1;
         end else begin
            decelStop_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // local/remote selection
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         remoteMode_q <= 1'b0;
      end else if (busRules && localRemoteFromBus) begin
         remoteMode_q <= commandWord_q[`DSCW_CW_REMOTE];
      end else begin
         remoteMode_q <= panelRemote;
      end
   end

   // ------------------------------------------------------------
   // ramp set selection
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ramp2Select_q <= 1'b0;
      end else if (busRules && rampSetFromBus) begin
         ramp2Select_q <= commandWord_q[`DSCW_CW_RAMP2];
      end else begin
         ramp2Select_q <= panelRamp2;
      end
   end

   // ------------------------------------------------------------
   // previous fault reset bit
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fltRstPrev_q <= 1'b0;
      end else begin
         fltRstPrev_q <= commandWord_q[`DSCW_CW_FLTRST];
      end
   end

   // ------------------------------------------------------------
   // fault reset, rising edge while faulted
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         faultResetPulse_q <= 1'b0;
      end else begin
         faultResetPulse_q <= busRules && faultPresent &&
                              commandWord_q[`DSCW_CW_FLTRST] && !fltRstPrev_q;
      end
   end

   // ------------------------------------------------------------
   // reference direction
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         effectiveReference_q <= 16'sh0000;
      end else if (busRules && !commandWord_q[`DSCW_CW_DIR]) begin
         if (speedReference == -16'sh8000) begin
            effectiveReference_q <= 16'sh7FFF;
         end else begin
            effectiveReference_q <= -speedReference;
         end
      end else begin
         effectiveReference_q <= speedReference;
      end
   end

endmodule : dscw_bank
`default_nettype wire

// ==== src/dscw_defines.svh ====
// dscw_defines.svh: offsets, bit positions, reset values and scale constants
`ifndef DSCW_DEFINES_SVH
`define DSCW_DEFINES_SVH

// ------------------------------------------------------------
// parameter access indices
// ------------------------------------------------------------
`define DSCW_IDX_STATUS      2'h0
`define DSCW_IDX_SPEED       2'h1
`define DSCW_IDX_COMMAND     2'h2

// ------------------------------------------------------------
// status word bit positions
// ------------------------------------------------------------
`define DSCW_ST_QSTOP        4
`define DSCW_ST_RAMP2        5
`define DSCW_ST_CONFIG       6
`define DSCW_ST_ALARM        7
`define DSCW_ST_RUNNING      8
`define DSCW_ST_ENABLED      9
`define DSCW_ST_FORWARD      10
`define DSCW_ST_INCH         11
`define DSCW_ST_REMOTE       12
`define DSCW_ST_UNDERV       13
`define DSCW_ST_AUTO         14
`define DSCW_ST_FAULT        15

// ------------------------------------------------------------
// command word bit positions
// ------------------------------------------------------------
`define DSCW_CW_RUN          0
`define DSCW_CW_ENABLE       1
`define DSCW_CW_DIR          2
`define DSCW_CW_INCH         3
`define DSCW_CW_REMOTE       4
`define DSCW_CW_RAMP2        5
`define DSCW_CW_QSTOP        6
`define DSCW_CW_FLTRST       7
`define DSCW_CW_USED_MASK    16'h00FF

// ------------------------------------------------------------
// reset values and speed scale
// ------------------------------------------------------------
`define DSCW_CMD_RESET       16'h0000
`define DSCW_SPEED_RATED     32'sh0000_2000
`define DSCW_SPEED_MAX       32'sh0000_7FFF
`define DSCW_SPEED_MIN       -32'sh0000_8000

`endif

// ==== src/dscw_pkg.sv ====
// dscw_pkg.sv: types of the drive status and control word bank
package dscw_pkg;

   typedef enum logic [1:0] {
      DSCW_SRC_NONE,
      DSCW_SRC_FIELDBUS,
      DSCW_SRC_PANEL
   } dscw_src_t;

   typedef enum {
      DSCW_IDLE,
      DSCW_ACCESS
   } dscw_state_t;

endpackage : dscw_pkg

// ==== src/dscw_speed_scale.sv ====
// dscw_speed_scale.sv: signed speed to 13-bit rated scale with saturation
`timescale 1ns/1ps
`default_nettype none
`include "dscw_defines.svh"

module dscw_speed_scale (
   // clock and reset
   input  wire  logic               core_clk,
   input  wire  logic               rst,
   // speed in, signed, same unit as rated
   input  wire  logic signed [15:0] actualSpeed,
   input  wire  logic        [15:0] ratedFreq,
   // scaled word
   output var   logic signed [15:0] speedWord_q
);

   logic signed [31:0] product;
   logic signed [31:0] quotient;
   logic signed [16:0] ratedSigned;

   // ------------------------------------------------------------
   // scale: speed * 8192 / rated, then clamp
   // ------------------------------------------------------------
   always_comb begin
      ratedSigned = $signed({1'b0, ratedFreq});
      product     = 32'(actualSpeed) * `DSCW_SPEED_RATED;
      if (ratedFreq == 16'h0000) begin
         quotient = 32'sh0000_0000;
      end else begin
         quotient = product / 32'(ratedSigned);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         speedWord_q <= 16'sh0000;
      end else if (quotient > `DSCW_SPEED_MAX) begin
         speedWord_q <= 16'sh7FFF;
      end else if (quotient < `DSCW_SPEED_MIN) begin
         speedWord_q <= -16'sh8000;
      end else begin
         speedWord_q <= quotient[15:0];
      end
   end

endmodule : dscw_speed_scale
`default_nettype wire

// ==== test/dscw_bank_chk.sv ====
// dscw_bank_chk.sv: port assertions of the status and command word bank
`timescale 1ns/1ps
`default_nettype none
`include "dscw_defines.svh"

module dscw_bank_chk (
   // clock and reset
   input wire logic                core_clk,
   input wire logic                rst,
   // parameter port
   input wire logic                paramRead,
   input wire logic                paramWrite,
   input wire logic [1:0]          paramIndex,
   input wire dscw_pkg::dscw_src_t paramSource,
   input wire logic [15:0]         paramRdData_q,
   input wire logic                paramRdValid_q,
   input wire logic                paramWrRefused_q,
   // conditions and commands
   input wire logic                fieldbusSelected,
   input wire logic                quickStopActive,
   input wire logic                alarmPresent,
   input wire logic                faultPresent,
   input wire logic                driveReady,
   input wire logic                configMode,
   input wire logic                enableCmd_q,
   input wire logic                runCmd_q,
   input wire logic                quickStopCmd_q,
   input wire logic                faultResetPulse_q
);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic rdSt;
   assign rdSt = paramRead && paramIndex == `DSCW_IDX_STATUS;

   a_read_valid: assert property (paramRead |=> paramRdValid_q)
      else $error("read not answered");
   a_valid_idle: assert property (!paramRead |=> !paramRdValid_q)
      else $error("valid without read");
   a_refuse_pulse: assert property (paramWrite && (paramIndex != `DSCW_IDX_COMMAND ||
      paramSource != dscw_pkg::DSCW_SRC_FIELDBUS) |=> paramWrRefused_q) else $error("write not refused");
   a_status_qstop: assert property (rdSt |=> paramRdData_q[4] == $past(quickStopActive))
      else $error("quick stop bit wrong");
   a_reserved_zero: assert property (rdSt |=> paramRdData_q[3:0] == 4'h0)
      else $error("reserved status bits set");
   a_status_alarm: assert property (rdSt |=> paramRdData_q[7] == $past(alarmPresent))
      else $error("alarm bit wrong");
   a_status_fault: assert property (rdSt |=> paramRdData_q[15] == $past(faultPresent))
      else $error("fault bit wrong");
   a_status_enable: assert property (rdSt |=>
      paramRdData_q[9] == $past(enableCmd_q && driveReady && !configMode)) else $error("enable bit wrong");
   a_bus_gate: assert property (!fieldbusSelected |=> !runCmd_q && !enableCmd_q && !quickStopCmd_q)
      else $error("command acts without fieldbus");
   a_reset_pulse: assert property (faultResetPulse_q |=> !faultResetPulse_q)
      else $error("fault reset not a pulse");
   a_cmd_reserved: assert property (paramRead && paramIndex == `DSCW_IDX_COMMAND |=>
      paramRdData_q[15:8] == 8'h00) else $error("reserved command bits kept");

   c_fault_read: cover property (rdSt ##1 paramRdData_q[15]);
   c_refused: cover property (paramWrRefused_q);
   c_fault_reset: cover property (faultResetPulse_q);
endmodule : dscw_bank_chk
`default_nettype wire

// ==== test/dscw_master_model.sv ====
// dscw_master_model.sv: network master issuing parameter reads and writes
`timescale 1ns/1ps
`default_nettype none

module dscw_master_model (
   // clock
   input  wire logic                core_clk,
   // parameter port toward the bank
   output var  logic                paramRead,
   output var  logic                paramWrite,
   output var  logic [1:0]          paramIndex,
   output var  logic [15:0]         paramWrData,
   output var  dscw_pkg::dscw_src_t paramSource,
   input  wire logic [15:0]         paramRdData_q,
   input  wire logic                paramRdValid_q
);
   initial begin
      paramRead = 1'b0;
      paramWrite = 1'b0;
      paramIndex = 2'h0;
      paramWrData = 16'h0000;
      paramSource = dscw_pkg::DSCW_SRC_NONE;
   end
   // one word write, source named by caller
   task automatic put(input logic [1:0] idx, input logic [15:0] data, input dscw_pkg::dscw_src_t src);
      @(negedge core_clk);
      paramWrite = 1'b1;
      paramIndex = idx;
      paramWrData = data;
      paramSource = src;
      @(negedge core_clk);
      paramWrite = 1'b0;
      paramWrData = ~data;
   endtask : put
   // one word read, answer taken one cycle later
   task automatic get(input logic [1:0] idx, output logic [15:0] data, output logic ok);
      @(negedge core_clk);
      paramRead = 1'b1;
      paramIndex = idx;
      @(negedge core_clk);
      paramRead = 1'b0;
      ok = paramRdValid_q;
      data = paramRdData_q;
   endtask : get
endmodule : dscw_master_model
`default_nettype wire

// ==== test/test_drive_status_control_words.sv ====
// test_drive_status_control_words.sv: self-checking bench of the word bank
`timescale 1ns/1ps
`default_nettype none

module test_drive_status_control_words;
   logic                core_clk, rst, fieldbusSelected, localRemoteFromBus, rampSetFromBus;
   logic                paramRead, paramWrite, paramRdValid_q, paramWrRefused_q, runCmd_q, decelStop_q;
   logic                enableCmd_q, inchCmd_q, remoteMode_q, ramp2Select_q, quickStopCmd_q, faultResetPulse_q;
   logic [1:0]          paramIndex;
   logic [15:0]         paramWrData, paramRdData_q, cond, ratedMotorFrequency, d;
   logic signed [15:0]  actualSpeed, speedReference, effectiveReference_q;
   dscw_pkg::dscw_src_t paramSource;
   int                  mismatches, checksDone, n;

   dscw_bank u_dscw_bank (.core_clk, .rst, .paramRead, .paramWrite, .paramIndex, .paramWrData, .paramSource,
      .paramRdData_q, .paramRdValid_q, .paramWrRefused_q, .fieldbusSelected, .localRemoteFromBus,
      .rampSetFromBus, .quickStopActive(cond[4]), .panelRamp2(cond[5]), .configMode(cond[6]),
      .alarmPresent(cond[7]), .motorRunning(cond[8]), .driveReady(cond[9]), .rotatingForward(cond[10]),
      .panelInch(cond[11]), .panelRemote(cond[12]), .underVoltage(cond[13]), .controllerAuto(cond[14]),
      .faultPresent(cond[15]), .actualSpeed, .ratedMotorFrequency, .speedReference, .runCmd_q, .decelStop_q,
      .enableCmd_q, .inchCmd_q, .remoteMode_q, .ramp2Select_q, .quickStopCmd_q, .faultResetPulse_q,
      .effectiveReference_q);
   dscw_master_model u_dscw_master_model (.core_clk, .paramRead, .paramWrite, .paramIndex, .paramWrData,
      .paramSource, .paramRdData_q, .paramRdValid_q);

   always #10 core_clk = ~core_clk;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checksDone++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc
   task automatic rdw(input logic [1:0] idx, output logic [15:0] v);
      logic ok;
      u_dscw_master_model.get(idx, v, ok);
      chk("read valid", 16'h0001, {15'h0000, ok});
   endtask : rdw
   task automatic wrw(input logic [15:0] v);
      u_dscw_master_model.put(2'h2, v, dscw_pkg::DSCW_SRC_FIELDBUS);
   endtask : wrw
   task automatic t_status();
      for (int b = 0; b < 16; b++) begin
         cond = 16'h0001 << b;
         cyc(2);
         rdw(2'h0, d);
         chk("status bit", (b > 3 && b != 9) ? cond : 16'h0000, d);
      end
   endtask : t_status
   task automatic t_commands();
      fieldbusSelected = 1'b1;
      localRemoteFromBus = 1'b1;
      rampSetFromBus = 1'b1;
      cond = 16'h0300;
      wrw(16'hFF7F);
      cyc(2);
      chk("command outputs", {10'h000, runCmd_q, enableCmd_q, inchCmd_q, remoteMode_q, ramp2Select_q, quickStopCmd_q}, 16'h003F);
      rdw(2'h2, d);
      chk("command readback", 16'h007F, d);
      rdw(2'h0, d);
      chk("status from commands", 16'h1B20, d);
      chk("run kept after reads", 16'h0001, {15'h0000, runCmd_q});
      {localRemoteFromBus, rampSetFromBus} = 2'h0;
      cond = 16'h0200;
      cyc(2);
      chk("panel selections", 16'h0000, {14'h0000, remoteMode_q, ramp2Select_q});
      wrw(16'h0002);
      cyc(2);
      chk("decel stop", 16'h0001, {15'h0000, decelStop_q});
      fieldbusSelected = 1'b0;
      cyc(2);
      chk("enable without bus", 16'h0000, {15'h0000, enableCmd_q});
   endtask : t_commands
   task automatic t_refuse();
      logic [1:0]          idx[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
      dscw_pkg::dscw_src_t src[4] = '{dscw_pkg::DSCW_SRC_FIELDBUS, dscw_pkg::DSCW_SRC_FIELDBUS,
                                      dscw_pkg::DSCW_SRC_PANEL, dscw_pkg::DSCW_SRC_NONE};
      for (int i = 0; i < 4; i++) begin
         u_dscw_master_model.put(idx[i], 16'h00FF, src[i]);
         chk("refused pulse", 16'h0001, {15'h0000, paramWrRefused_q});
         rdw(2'h2, d);
         chk("command unchanged", 16'h0002, d);
      end
   endtask : t_refuse
   task automatic t_direction();
      logic [15:0] refs[4] = '{16'h0064, 16'h0064, 16'h8000, 16'h8000};
      logic [15:0] cmds[4] = '{16'h0004, 16'h0000, 16'h0000, 16'h0004};
      logic [15:0] exps[4] = '{16'h0064, 16'hFF9C, 16'h7FFF, 16'h8000};
      fieldbusSelected = 1'b1;
      for (int i = 0; i < 4; i++) begin
         speedReference = refs[i];
         wrw(cmds[i]);
         cyc(3);
         chk("effective reference", exps[i], effectiveReference_q);
      end
   endtask : t_direction
   task automatic t_fault(input logic flt, input logic [15:0] exp);
      cond = {flt, 15'h0000};
      wrw(16'h0000);
      wrw(16'h0080);
      n = 0;
      repeat (4) begin
         @(negedge core_clk);
         n += faultResetPulse_q;
      end
      chk("fault reset pulses", exp, n[15:0]);
   endtask : t_fault
   task automatic t_speed();
      logic [15:0] rat[6] = '{16'h003C, 16'h003C, 16'h003C, 16'h003C, 16'h003C, 16'h0000};
      logic [15:0] act[6] = '{16'h003C, 16'h001E, 16'hFFF1, 16'h012C, 16'hFED4, 16'h0032};
      logic [15:0] exps[6] = '{16'h2000, 16'h1000, 16'hF800, 16'h7FFF, 16'h8000, 16'h0000};
      for (int i = 0; i < 6; i++) begin
         ratedMotorFrequency = rat[i];
         actualSpeed = act[i];
         cyc(2);
         rdw(2'h1, d);
         chk("speed word", exps[i], d);
      end
   endtask : t_speed
   task automatic wrap_up();
      if (mismatches == 0 && checksDone > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      {core_clk, fieldbusSelected, localRemoteFromBus, rampSetFromBus} = 4'h0;
      rst = 1'b1;
      cond = 16'h0000;
      actualSpeed = 16'h0000;
      speedReference = 16'h0000;
      ratedMotorFrequency = 16'h0000;
      cyc(2);
      rst = 1'b0;
      rdw(2'h2, d);
      chk("command word reset", 16'h0000, d);
      rdw(2'h3, d);
      chk("unmapped index", 16'h0000, d);
      t_status();
      t_commands();
      t_refuse();
      t_direction();
      t_fault(1'b1, 16'h0001);
      t_fault(1'b0, 16'h0000);
      t_speed();
      wrap_up();
   end
endmodule : test_drive_status_control_words

bind dscw_bank dscw_bank_chk u_dscw_bank_chk (.core_clk, .rst, .paramRead, .paramWrite, .paramIndex,
   .paramSource, .paramRdData_q, .paramRdValid_q, .paramWrRefused_q, .fieldbusSelected, .quickStopActive,
   .alarmPresent, .faultPresent, .driveReady, .configMode, .enableCmd_q, .runCmd_q, .quickStopCmd_q,
   .faultResetPulse_q);
`default_nettype wire
